// >>> verilog/rtc_pkg.sv
// constants, encodings and types of the retimer strap and control block
package rtc_pkg;
    localparam int AXI_AW = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;

    localparam int CTRL_DEEMPH_LSB = 0;
    localparam int CTRL_EQ_LSB = 2;
    localparam logic [1:0] DEEMPH_0DB = 2'h0;
    localparam logic [1:0] DEEMPH_M2DB = 2'h1;
    localparam logic [1:0] DEEMPH_RSVD = 2'h3;
    localparam logic [1:0] EQ_FIXED_7P5 = 2'h0;
    localparam logic [1:0] EQ_ADAPTIVE = 2'h1;
    localparam logic [1:0] EQ_FIXED_14 = 2'h2;
    localparam logic [1:0] CTRL_DEEMPH_RST = DEEMPH_0DB;
    localparam logic [1:0] CTRL_EQ_RST = EQ_ADAPTIVE;

    localparam int ST_OE = 0;
    localparam int ST_SIGEN = 1;
    localparam int ST_CLKV = 2;
    localparam int ST_STBY = 3;
    localparam int ST_MODE = 4;
    localparam int ST_DLVL = 5;
    localparam int ST_ELVL = 7;
    localparam int ST_HPD = 9;
    localparam int ST_DEEMPH = 10;
    localparam int ST_EQ = 12;
    localparam int ST_PDOWN = 14;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // pin order inside the synchroniser vector
    localparam int PIN_OE = 0;
    localparam int PIN_SIGEN = 1;
    localparam int PIN_CLKV = 2;
    localparam int PIN_MODE = 3;
    localparam int PIN_HPD = 4;
    localparam int PIN_D_ABOVE = 5;
    localparam int PIN_D_BELOW = 6;
    localparam int PIN_E_ABOVE = 7;
    localparam int PIN_E_BELOW = 8;
    localparam int PIN_COUNT = 9;

    typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} rtc_level_t;
    typedef enum logic [1:0] {PWR_OFF, PWR_ACTIVE, PWR_STANDBY} rtc_state_t;
endpackage

// >>> verilog/rtc_strap_if.sv
// carrier between a three-level strap comparator pair and its decoder
`timescale 1ns/10ps
`default_nettype none
interface rtc_strap_if;
    logic above;
    logic below;
    rtc_pkg::rtc_level_t level;
    modport dec (input above, input below, output level);
    modport user (output above, output below, input level);
endinterface
`default_nettype wire

// >>> verilog/rtc_sync.sv
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/10ps
`default_nettype none
module rtc_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    meta[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    meta[i] <= d[i];
                    q[i] <= meta[i];
                end
            end
        end
    endgenerate
endmodule // rtc_sync
`default_nettype wire

// >>> verilog/rtc_strap_decode.sv
// three-level strap decoder from a synchronised comparator pair
`timescale 1ns/10ps
`default_nettype none
module rtc_strap_decode (
    input wire logic aclk,
    input wire logic aresetn,
    rtc_strap_if.dec s
);
    // both comparators tripping at once is impossible on a sane pin; treat as mid
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s.level <= rtc_pkg::LVL_MID;
        end else if (s.above && !s.below) begin
            s.level <= rtc_pkg::LVL_HIGH;
        end else if (s.below && !s.above) begin
            s.level <= rtc_pkg::LVL_LOW;
        end else begin
            s.level <= rtc_pkg::LVL_MID;
        end
    end

    property p_no_glitch;
        @(posedge aclk) disable iff (!aresetn)
        (s.above && !s.below) |=> s.level == rtc_pkg::LVL_HIGH;
    endproperty
    a_no_glitch: assert property (p_no_glitch)
        else $error("strap decoder missed a high level");
endmodule // rtc_strap_decode
`default_nettype wire

// >>> verilog/rtc_top.sv
// strap, control pin and register logic of the retimer
`timescale 1ns/10ps
`default_nettype none
module rtc_top (
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins, asynchronous to aclk
    input wire logic operation_enable,
    input wire logic signal_detector_enable,
    input wire logic input_clock_valid,
    input wire logic control_mode_select,
    input wire logic hot_plug_in_from_sink,
    input wire logic deemph_strap_above,
    input wire logic deemph_strap_below,
    input wire logic equalizer_strap_addr_bit_above,
    input wire logic equalizer_strap_addr_bit_below,
    // control outputs
    output logic power_down,
    output logic internal_reset,
    output logic detector_on,
    output logic standby,
    output logic serial_bus_mode,
    output logic [1:0] deemph_setting,
    output logic [1:0] eq_setting,
    output logic target_addr_bit1,
    output logic hot_plug_out_to_source
);
    logic [rtc_pkg::PIN_COUNT-1:0] pins_raw;
    logic [rtc_pkg::PIN_COUNT-1:0] pins;
    logic oe_s;
    logic oe_q;
    logic oe_fall;
    logic signal_detector_enable_s;
    logic clkv_s;
    logic mode_s;
    logic hpd_s;
    rtc_pkg::rtc_state_t state;
    rtc_pkg::rtc_state_t next_state;
    logic [1:0] ctrl_deemph;
    logic [1:0] ctrl_eq;
    logic [1:0] next_deemph;
    logic [1:0] next_eq;
    logic aw_got;
    logic w_got;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_commit;
    logic ctrl_hit;
    logic [31:0] status_word;

    rtc_strap_if deemph_if ();
    rtc_strap_if eq_if ();

    assign pins_raw = {equalizer_strap_addr_bit_below, equalizer_strap_addr_bit_above,
        deemph_strap_below, deemph_strap_above, hot_plug_in_from_sink,
        control_mode_select, input_clock_valid, signal_detector_enable, operation_enable};

    rtc_sync #(.W(rtc_pkg::PIN_COUNT)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(pins_raw),
        .q(pins)
    );

    assign oe_s = pins[rtc_pkg::PIN_OE];
    assign signal_detector_enable_s = pins[rtc_pkg::PIN_SIGEN];
    assign clkv_s = pins[rtc_pkg::PIN_CLKV];
    assign mode_s = pins[rtc_pkg::PIN_MODE];
    assign hpd_s = pins[rtc_pkg::PIN_HPD];
    assign deemph_if.above = pins[rtc_pkg::PIN_D_ABOVE];
    assign deemph_if.below = pins[rtc_pkg::PIN_D_BELOW];
    assign eq_if.above = pins[rtc_pkg::PIN_E_ABOVE];
    assign eq_if.below = pins[rtc_pkg::PIN_E_BELOW];

    rtc_strap_decode u_deemph_dec (
        .aclk(aclk),
        .aresetn(aresetn),
        .s(deemph_if.dec)
    );

    rtc_strap_decode u_eq_dec (
        .aclk(aclk),
        .aresetn(aresetn),
        .s(eq_if.dec)
    );

    // operation enable edge; reset value matches the synchroniser's reset output,
    // otherwise the first edge after release would fake a fall and pulse internal_reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= oe_s;
        end
    end
    assign oe_fall = oe_q && !oe_s;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            internal_reset <= 1'b0;
        end else begin
            internal_reset <= oe_fall;
        end
    end

    // power state
    always_comb begin
        next_state = state;
        case (state)
            rtc_pkg::PWR_OFF: begin
                if (oe_s && signal_detector_enable_s && !clkv_s) begin
                    next_state = rtc_pkg::PWR_STANDBY;
                end else if (oe_s) begin
                    next_state = rtc_pkg::PWR_ACTIVE;
                end
            end
            rtc_pkg::PWR_ACTIVE: begin
                if (signal_detector_enable_s && !clkv_s) begin
                    next_state = rtc_pkg::PWR_STANDBY;
                end
            end
            rtc_pkg::PWR_STANDBY: begin
                if (!signal_detector_enable_s || clkv_s) begin
                    next_state = rtc_pkg::PWR_ACTIVE;
                end
            end
            default: begin
                next_state = rtc_pkg::PWR_OFF;
            end
        endcase
        if (!oe_s) begin
            next_state = rtc_pkg::PWR_OFF;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= rtc_pkg::PWR_OFF;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_down <= 1'b1;
            standby <= 1'b0;
            detector_on <= 1'b0;
        end else begin
            power_down <= (next_state == rtc_pkg::PWR_OFF);
            standby <= (next_state == rtc_pkg::PWR_STANDBY);
            detector_on <= signal_detector_enable_s && oe_s;
        end
    end

    // effective strap-controllable settings
    always_comb begin
        if (mode_s) begin
            next_deemph = ctrl_deemph;
            next_eq = ctrl_eq;
        end else begin
            case (deemph_if.level)
                rtc_pkg::LVL_LOW: next_deemph = rtc_pkg::DEEMPH_M2DB;
                rtc_pkg::LVL_MID: next_deemph = rtc_pkg::DEEMPH_0DB;
                default: next_deemph = rtc_pkg::DEEMPH_RSVD;
            endcase
            case (eq_if.level)
                rtc_pkg::LVL_LOW: next_eq = rtc_pkg::EQ_FIXED_7P5;
                rtc_pkg::LVL_MID: next_eq = rtc_pkg::EQ_ADAPTIVE;
                default: next_eq = rtc_pkg::EQ_FIXED_14;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            deemph_setting <= rtc_pkg::CTRL_DEEMPH_RST;
            eq_setting <= rtc_pkg::CTRL_EQ_RST;
            serial_bus_mode <= 1'b0;
            target_addr_bit1 <= 1'b0;
            hot_plug_out_to_source <= 1'b0;
        end else begin
            deemph_setting <= next_deemph;
            eq_setting <= next_eq;
            serial_bus_mode <= mode_s;
            // pin is driven two-level in bus mode, so only the low comparator matters
            target_addr_bit1 <= mode_s && !eq_if.below;
            hot_plug_out_to_source <= hpd_s;
        end
    end

    // write channel: address and data taken in either order, one write at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            s_axi_awready <= 1'b1;
            wr_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got <= 1'b1;
            s_axi_awready <= 1'b0;
            wr_addr <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_got <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got <= 1'b0;
            s_axi_wready <= 1'b1;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got <= 1'b1;
            s_axi_wready <= 1'b0;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_got <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    assign wr_commit = aw_got && w_got && !s_axi_bvalid;
    assign ctrl_hit = (wr_addr[7:2] == rtc_pkg::ADDR_CTRL[7:2]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rtc_pkg::RESP_OKAY;
        end else if (wr_commit) begin
            s_axi_bvalid <= 1'b1;
            if (ctrl_hit || wr_addr[7:2] == rtc_pkg::ADDR_STATUS[7:2]) begin
                s_axi_bresp <= rtc_pkg::RESP_OKAY;
            end else begin
                s_axi_bresp <= rtc_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // control register; strap mode keeps the strap values in charge
    always_ff @(posedge aclk) begin
        if (!aresetn || oe_fall) begin
            ctrl_deemph <= rtc_pkg::CTRL_DEEMPH_RST;
            ctrl_eq <= rtc_pkg::CTRL_EQ_RST;
        end else if (wr_commit && ctrl_hit && wr_strb[0] && mode_s) begin
            ctrl_deemph <= wr_data[rtc_pkg::CTRL_DEEMPH_LSB +: 2];
            ctrl_eq <= wr_data[rtc_pkg::CTRL_EQ_LSB +: 2];
        end
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[rtc_pkg::ST_OE] = oe_s;
        status_word[rtc_pkg::ST_SIGEN] = signal_detector_enable_s;
        status_word[rtc_pkg::ST_CLKV] = clkv_s;
        status_word[rtc_pkg::ST_STBY] = standby;
        status_word[rtc_pkg::ST_MODE] = mode_s;
        status_word[rtc_pkg::ST_DLVL +: 2] = deemph_if.level;
        status_word[rtc_pkg::ST_ELVL +: 2] = eq_if.level;
        status_word[rtc_pkg::ST_HPD] = hpd_s;
        status_word[rtc_pkg::ST_DEEMPH +: 2] = deemph_setting;
        status_word[rtc_pkg::ST_EQ +: 2] = eq_setting;
        status_word[rtc_pkg::ST_PDOWN] = power_down;
    end

    // read channel: answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= rtc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rtc_pkg::RESP_OKAY;
            if (s_axi_araddr[7:2] == rtc_pkg::ADDR_CTRL[7:2]) begin
                s_axi_rdata <= {28'h0000000, ctrl_eq, ctrl_deemph};
            end else if (s_axi_araddr[7:2] == rtc_pkg::ADDR_STATUS[7:2]) begin
                s_axi_rdata <= status_word;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= rtc_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_oe_drop;
        oe_q && !oe_s;
    endsequence
    sequence s_cfg_default;
        ctrl_deemph == rtc_pkg::CTRL_DEEMPH_RST && ctrl_eq == rtc_pkg::CTRL_EQ_RST;
    endsequence
    sequence s_wr_strap;
        wr_commit && !mode_s && !oe_fall;
    endsequence
    sequence s_wr_both;
        aw_got && w_got && !s_axi_bvalid;
    endsequence

    property p_power_down;
        !oe_s |=> power_down && !standby;
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("power-down not entered with enable low");

    property p_oe_fall;
        s_oe_drop |=> internal_reset ##0 s_cfg_default;
    endproperty
    a_oe_fall: assert property (p_oe_fall)
        else $error("enable fall did not reset state");

    property p_detector_off;
        !signal_detector_enable_s |=> !detector_on ##0 !standby;
    endproperty
    a_detector_off: assert property (p_detector_off)
        else $error("detector on while its enable is low");

    property p_standby;
        (oe_s && signal_detector_enable_s && !clkv_s) |=> standby ##0 !power_down;
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby not entered without valid clock");

    property p_deemph_strap;
        (!mode_s && deemph_if.level == rtc_pkg::LVL_LOW) |=>
            deemph_setting == rtc_pkg::DEEMPH_M2DB;
    endproperty
    a_deemph_strap: assert property (p_deemph_strap)
        else $error("low de-emphasis strap not mapped to -2 dB");

    property p_deemph_bus;
        mode_s |=> deemph_setting == $past(ctrl_deemph);
    endproperty
    a_deemph_bus: assert property (p_deemph_bus)
        else $error("bus mode de-emphasis not from register");

    property p_eq_strap;
        (!mode_s && eq_if.level == rtc_pkg::LVL_HIGH) |=> eq_setting == rtc_pkg::EQ_FIXED_14;
    endproperty
    a_eq_strap: assert property (p_eq_strap)
        else $error("high equalizer strap not mapped to 14 dB");

    property p_addr_bit;
        mode_s |=> target_addr_bit1 == !$past(eq_if.below) ##0 serial_bus_mode;
    endproperty
    a_addr_bit: assert property (p_addr_bit)
        else $error("address bit not taken from equalizer pin");

    property p_strap_wins;
        s_wr_strap |=> $stable(ctrl_deemph) && $stable(ctrl_eq);
    endproperty
    a_strap_wins: assert property (p_strap_wins)
        else $error("register write took effect in strap mode");

    property p_write_answer;
        s_wr_both |=> s_axi_bvalid [*1] ##0 !s_axi_awready;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write response late");

    property p_hot_plug;
        hpd_s |=> hot_plug_out_to_source;
    endproperty
    a_hot_plug: assert property (p_hot_plug)
        else $error("hot-plug output does not follow input");
endmodule // rtc_top
`default_nettype wire

// >>> verif/rtc_board_model.sv
// board straps and pin pulls around the control pins of the retimer
`timescale 1ns/10ps
`default_nettype none
module rtc_board_model (
    input wire logic oe_driven,
    input wire logic oe_level,
    input wire logic sd_driven,
    input wire logic sd_level,
    input wire logic [1:0] deemph_strap,
    input wire logic [1:0] eq_strap,
    output logic operation_enable,
    output logic signal_detector_enable,
    output logic deemph_above,
    output logic deemph_below,
    output logic eq_above,
    output logic eq_below
);
    // a released pin settles to its weak internal pull, never to the last driven level
    assign operation_enable = oe_driven ? oe_level : 1'b1;
    assign signal_detector_enable = sd_driven ? sd_level : 1'b0;
    // resistor to supply trips the upper comparator, to ground the lower, open trips neither
    assign deemph_above = (deemph_strap == rtc_pkg::LVL_HIGH);
    assign deemph_below = (deemph_strap == rtc_pkg::LVL_LOW);
    assign eq_above = (eq_strap == rtc_pkg::LVL_HIGH);
    assign eq_below = (eq_strap == rtc_pkg::LVL_LOW);
endmodule // rtc_board_model
`default_nettype wire

// >>> verif/rtc_top_bench.sv
// self-checking bench of the retimer strap and control block
`timescale 1ns/10ps
`default_nettype none
module rtc_top_bench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic oe_dr = 1'b0;
    logic oe_lv = 1'b1;
    logic sd_dr = 1'b0;
    logic sd_lv = 1'b0;
    logic clkv = 1'b1;
    logic mode = 1'b0;
    logic hpd = 1'b0;
    logic [1:0] dst = rtc_pkg::LVL_MID;
    logic [1:0] est = rtc_pkg::LVL_MID;
    logic awready, wready, bvalid, arready, rvalid, oe, sd, da, db, ea, eb;
    logic [1:0] bresp, rresp, deemph_setting, eq_setting;
    logic [31:0] rdata, d;
    logic [1:0] r;
    logic power_down, internal_reset, detector_on, standby, serial_bus_mode;
    logic target_addr_bit1, hot_plug_out_to_source;
    logic [1:0] dexp [3] = '{rtc_pkg::DEEMPH_M2DB, rtc_pkg::DEEMPH_0DB, rtc_pkg::DEEMPH_RSVD};
    logic [1:0] eexp [3] = '{rtc_pkg::EQ_FIXED_7P5, rtc_pkg::EQ_ADAPTIVE, rtc_pkg::EQ_FIXED_14};
    logic [31:0] ctrl_rst = {28'h0, rtc_pkg::CTRL_EQ_RST, rtc_pkg::CTRL_DEEMPH_RST};
    logic [31:0] wv = {28'h0, rtc_pkg::EQ_FIXED_14, rtc_pkg::DEEMPH_M2DB};
    int n_fail = 0;
    int cmp_count = 0;
    int k;

    always #12.5 aclk = ~aclk;

    rtc_board_model rtc_board_model_i (.oe_driven(oe_dr), .oe_level(oe_lv), .sd_driven(sd_dr),
        .sd_level(sd_lv), .deemph_strap(dst), .eq_strap(est), .operation_enable(oe),
        .signal_detector_enable(sd), .deemph_above(da), .deemph_below(db), .eq_above(ea),
        .eq_below(eb));

    rtc_top rtc_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .operation_enable(oe),
        .signal_detector_enable(sd), .input_clock_valid(clkv), .control_mode_select(mode),
        .hot_plug_in_from_sink(hpd), .deemph_strap_above(da), .deemph_strap_below(db),
        .equalizer_strap_addr_bit_above(ea), .equalizer_strap_addr_bit_below(eb),
        .power_down(power_down), .internal_reset(internal_reset), .detector_on(detector_on),
        .standby(standby), .serial_bus_mode(serial_bus_mode), .deemph_setting(deemph_setting),
        .eq_setting(eq_setting), .target_addr_bit1(target_addr_bit1),
        .hot_plug_out_to_source(hot_plug_out_to_source));

    task automatic tally_and_finish();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            n++;
            if (n > 200) begin
                n_fail++;
                tally_and_finish();
            end
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                rs = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            n++;
            if (n > 200) begin
                n_fail++;
                tally_and_finish();
            end
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                v = rdata;
                rs = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    // pins pass two sync flops, a decoder flop and an output flop
    task automatic settle();
        repeat (6) @(posedge aclk);
        #1;
    endtask

    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge aclk);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        // enable idles high through its pull, so no reset pulse may follow release
        k = 0;
        repeat (6) begin
            @(posedge aclk);
            #1;
            if (internal_reset === 1'b1) k++;
        end
        chk(k, 0);
        chk(power_down, 1'b0);
        chk(detector_on, 1'b0);
        axi_rd(rtc_pkg::ADDR_CTRL, d, r);
        chk(d, ctrl_rst);
        for (int i = 0; i < 3; i++) begin
            @(posedge aclk);
            dst <= i[1:0];
            est <= i[1:0];
            settle();
            chk(deemph_setting, dexp[i]);
            chk(eq_setting, eexp[i]);
            chk(target_addr_bit1, 1'b0);
        end
        axi_wr(rtc_pkg::ADDR_CTRL, wv, r);
        chk(r, rtc_pkg::RESP_OKAY);
        settle();
        chk(deemph_setting, rtc_pkg::DEEMPH_RSVD);
        @(posedge aclk);
        mode <= 1'b1;
        settle();
        chk(serial_bus_mode, 1'b1);
        chk(deemph_setting, rtc_pkg::CTRL_DEEMPH_RST);
        chk(target_addr_bit1, 1'b1);
        axi_wr(rtc_pkg::ADDR_CTRL, wv, r);
        @(posedge aclk);
        dst <= rtc_pkg::LVL_MID;
        est <= rtc_pkg::LVL_LOW;
        settle();
        chk(deemph_setting, rtc_pkg::DEEMPH_M2DB);
        chk(eq_setting, rtc_pkg::EQ_FIXED_14);
        chk(target_addr_bit1, 1'b0);
        axi_rd(rtc_pkg::ADDR_CTRL, d, r);
        chk(d, wv);
        axi_rd(rtc_pkg::ADDR_STATUS, d, r);
        chk(d[rtc_pkg::ST_MODE], 1'b1);
        axi_rd(8'h10, d, r);
        chk(d, 32'h0);
        chk(r, rtc_pkg::RESP_SLVERR);
        axi_wr(rtc_pkg::ADDR_STATUS, 32'hffff, r);
        chk(r, rtc_pkg::RESP_OKAY);
        @(posedge aclk);
        hpd <= 1'b1;
        settle();
        chk(hot_plug_out_to_source, 1'b1);
        @(posedge aclk);
        hpd <= 1'b0;
        sd_dr <= 1'b1;
        sd_lv <= 1'b1;
        clkv <= 1'b0;
        settle();
        chk(hot_plug_out_to_source, 1'b0);
        chk(detector_on, 1'b1);
        chk(standby, 1'b1);
        @(posedge aclk);
        clkv <= 1'b1;
        settle();
        chk(standby, 1'b0);
        @(posedge aclk);
        oe_dr <= 1'b1;
        oe_lv <= 1'b0;
        k = 0;
        repeat (8) begin
            @(posedge aclk);
            #1;
            if (internal_reset === 1'b1) k++;
        end
        chk(k, 1);
        chk(power_down, 1'b1);
        @(posedge aclk);
        oe_dr <= 1'b0;
        clkv <= 1'b0;
        settle();
        chk(power_down, 1'b0);
        chk(standby, 1'b1);
        chk(deemph_setting, rtc_pkg::CTRL_DEEMPH_RST);
        axi_rd(rtc_pkg::ADDR_CTRL, d, r);
        chk(d, ctrl_rst);
        tally_and_finish();
    end
endmodule // rtc_top_bench
`default_nettype wire
